// file: lpcm_edge.v
// Edge detector for a master clock sampled on clk_i; the frame sync is passed on as an active-high level.
// Assumes both inputs are already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module lpcm_edge (
  input wire clk_i,
  input wire reset_n_i,
  input wire mclk_i,
  input wire sync_n_i,
  output wire mclk_fall_o,
  output wire mclk_rise_o,
  output wire sync_low_o
);
  reg mclk_r;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      mclk_r <= 1'b0;
    end else begin
      mclk_r <= mclk_i;
    end
  end
  assign mclk_fall_o = mclk_r & ~mclk_i;
  assign mclk_rise_o = ~mclk_r & mclk_i;
  assign sync_low_o = ~sync_n_i;
endmodule // lpcm_edge
`default_nettype wire

// file: lpcm_far_end.sv
// Far-end frame timing logic: master clock, sync, receive data.
// Runs from the bench clock; every output changes on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module lpcm_far_end (
  input wire logic clk_i,
  input wire logic [15:0] word_i,
  output var logic mclk_o,
  output var logic sync_n_o,
  output var logic sdata_o
);
  logic [7:0] k = 8'hF0;
  logic [7:0] acc = 8'h00;
  logic [3:0] ph = 4'h0;
  logic [3:0] len = 4'hC;
  initial mclk_o = 1'b0;
  initial sync_n_o = 1'b1;
  initial sdata_o = 1'b0;
  // 25 MHz over 2.048 MHz is 12 and 53/256: that share of periods gets a 13th cycle
  always @(negedge clk_i) begin
    if (ph == len - 4'h1) begin
      ph <= 4'h0;
      mclk_o <= 1'b1;
      len <= (acc > 8'hCA) ? 4'hD : 4'hC;
      acc <= acc + 8'h35;
      k <= k + 8'h01;
      sync_n_o <= k + 8'h01 > 8'h01;
      // Toggles when idle so stale bits never match
      sdata_o <= k + 8'h01 < 8'h10 ? word_i[k[3:0] + 4'h1] : ~sdata_o;
    end else begin
      ph <= ph + 4'h1;
      // Six cycles high out of 12 or 13 keeps the duty within 46 to 50 percent
      if (ph == 4'h5) mclk_o <= 1'b0;
    end
  end
endmodule // lpcm_far_end
`default_nettype wire

// file: lpcm_map.vh
// Constants of the linear PCM codec serial port.
// Assumes a 25 MHz system clock; master clocks and syncs arrive as sampled inputs.
`ifndef LPCM_MAP_VH
`define LPCM_MAP_VH
`define LPCM_WORD_BITS 16
`define LPCM_CNT_W 5
`define LPCM_CNT_LAST 5'h10
`define LPCM_SAMPLE_RST 16'h0000
`define LPCM_GAIN_0DB 2'h0
`define LPCM_GAIN_UP3 2'h1
`define LPCM_GAIN_DN3 2'h2
`define LPCM_GAIN_BYP 2'h3
`endif

// file: lpcm_port.v
// Serial port of a linear PCM codec: encoder shift-out, decoder shift-in.
// Assumes master clocks and syncs are slow enough to sample at 25 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "lpcm_map.vh"
module lpcm_port (
  input wire clk_i,
  input wire reset_n_i,
  input wire tx_master_clk_i,
  input wire tx_frame_sync_n_i,
  output wire tx_serial_out_o,
  output wire tx_serial_oe_n_o,
  input wire rx_master_clk_i,
  input wire rx_frame_sync_n_i,
  input wire rx_serial_in_i,
  input wire tx_gain_select_i,
  input wire tx_filter_bypass_i,
  input wire tx_path_powerdown_i,
  input wire rx_gain_select_i,
  input wire rx_path_powerdown_i,
  input wire [15:0] tx_sample_i,
  output wire tx_sample_take_o,
  output wire [15:0] rx_sample_o,
  output wire rx_sample_valid_o,
  output wire [1:0] tx_gain_o,
  output wire [1:0] rx_gain_o,
  output wire tx_active_o,
  output wire rx_active_o
);
  // ==========================================================
  // Master clock edges
  // ==========================================================
  wire tx_fall;
  wire tx_rise;
  wire tx_sync_low;
  wire rx_fall;
  wire rx_sync_low;
  lpcm_edge u_tx_edge (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .mclk_i(tx_master_clk_i),
    .sync_n_i(tx_frame_sync_n_i),
    .mclk_fall_o(tx_fall),
    .mclk_rise_o(tx_rise),
    .sync_low_o(tx_sync_low)
  );
  lpcm_edge u_rx_edge (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .mclk_i(rx_master_clk_i),
    .sync_n_i(rx_frame_sync_n_i),
    .mclk_fall_o(rx_fall),
    .mclk_rise_o(),
    .sync_low_o(rx_sync_low)
  );

  // ==========================================================
  // Sync arming
  // ==========================================================
  // Armed when sync is seen high, so a long low pulse starts only one frame.
  reg tx_armed_r;
  reg rx_armed_r;
  wire tx_start = tx_armed_r & tx_sync_low & tx_fall & ~tx_path_powerdown_i;
  wire rx_start = rx_armed_r & rx_sync_low & rx_fall & ~rx_path_powerdown_i;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_armed_r <= 1'b0;
      rx_armed_r <= 1'b0;
    end else begin
      if (!tx_sync_low) begin
        tx_armed_r <= 1'b1;
      end else if (tx_fall) begin
        tx_armed_r <= 1'b0;
      end
      if (!rx_sync_low) begin
        rx_armed_r <= 1'b1;
      end else if (rx_fall) begin
        rx_armed_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Encoder shift-out
  // ==========================================================
  // Bit counter step, shared by both shifters
  function [`LPCM_CNT_W-1:0] lpcm_cnt_inc;
    input [`LPCM_CNT_W-1:0] cnt;
    begin
      lpcm_cnt_inc = cnt + 5'h01;
    end
  endfunction

  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;
  reg tx_state_r;
  reg [`LPCM_CNT_W-1:0] tx_cnt_r;
  reg [15:0] tx_shift_r;
  reg tx_bit_r;
  reg tx_drive_r;
  reg tx_take_r;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_state_r <= ST_IDLE;
      tx_cnt_r <= {`LPCM_CNT_W{1'b0}};
      tx_shift_r <= `LPCM_SAMPLE_RST;
      tx_bit_r <= 1'b0;
      tx_drive_r <= 1'b0;
      tx_take_r <= 1'b0;
    end else begin
      tx_take_r <= 1'b0;
      case (tx_state_r)
        ST_IDLE: begin
          tx_drive_r <= 1'b0;
          if (tx_start) begin
            // Fifteen-bit coder: LSB forced to zero
            tx_shift_r <= {1'b0, tx_sample_i[15:1]};
            tx_bit_r <= 1'b0;
            tx_drive_r <= 1'b1;
            tx_take_r <= 1'b1;
            tx_cnt_r <= 5'h01;
            tx_state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tx_path_powerdown_i) begin
            tx_drive_r <= 1'b0;
            tx_state_r <= ST_IDLE;
          end else if (tx_rise) begin
            // Next bit launched on rising edge, far end samples on falling
            if (tx_cnt_r == `LPCM_CNT_LAST) begin
              tx_drive_r <= 1'b0;
              tx_state_r <= ST_IDLE;
            end else begin
              tx_bit_r <= tx_shift_r[0];
              tx_shift_r <= {1'b0, tx_shift_r[15:1]};
              tx_cnt_r <= lpcm_cnt_inc(tx_cnt_r);
            end
          end
        end
        default: begin
          tx_state_r <= ST_IDLE;
          tx_drive_r <= 1'b0;
        end
      endcase
    end
  end
  assign tx_serial_out_o = tx_bit_r & tx_drive_r;
  assign tx_serial_oe_n_o = ~tx_drive_r;
  assign tx_sample_take_o = tx_take_r;
  assign tx_active_o = tx_drive_r;

  // ==========================================================
  // Decoder shift-in
  // ==========================================================
  reg rx_state_r;
  reg [`LPCM_CNT_W-1:0] rx_cnt_r;
  reg [15:0] rx_shift_r;
  reg [15:0] rx_word_r;
  reg rx_valid_r;
  wire [15:0] rx_shift_nxt = {rx_serial_in_i, rx_shift_r[15:1]};
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_state_r <= ST_IDLE;
      rx_cnt_r <= {`LPCM_CNT_W{1'b0}};
      rx_shift_r <= `LPCM_SAMPLE_RST;
      rx_word_r <= `LPCM_SAMPLE_RST;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      case (rx_state_r)
        ST_IDLE: begin
          if (rx_start) begin
            // First bit is valid at the reference edge
            rx_shift_r <= rx_shift_nxt;
            rx_cnt_r <= 5'h01;
            rx_state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (rx_path_powerdown_i) begin
            rx_state_r <= ST_IDLE;
          end else if (rx_fall) begin
            rx_shift_r <= rx_shift_nxt;
            if (rx_cnt_r == `LPCM_CNT_LAST - 5'h01) begin
              // Full 16 bits kept; converter side uses upper fifteen
              rx_word_r <= rx_shift_nxt;
              rx_valid_r <= 1'b1;
              rx_state_r <= ST_IDLE;
            end else begin
              rx_cnt_r <= lpcm_cnt_inc(rx_cnt_r);
            end
          end
        end
        default: begin
          rx_state_r <= ST_IDLE;
        end
      endcase
    end
  end
  assign rx_sample_o = rx_word_r;
  assign rx_sample_valid_o = rx_valid_r;
  assign rx_active_o = rx_state_r;

  // ==========================================================
  // Gain settings
  // ==========================================================
  assign tx_gain_o = tx_filter_bypass_i ? `LPCM_GAIN_BYP :
    (tx_gain_select_i ? `LPCM_GAIN_DN3 : `LPCM_GAIN_0DB);
  assign rx_gain_o = rx_gain_select_i ? `LPCM_GAIN_UP3 : `LPCM_GAIN_0DB;
endmodule // lpcm_port
`default_nettype wire

// file: lpcm_port_sva.sv
// Port checker for lpcm_port.
// Assumes the master clock is slower than clk_i over four.
`timescale 1ns/1ps
`default_nettype none
module lpcm_port_sva (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tx_master_clk_i,
  input wire logic tx_frame_sync_n_i,
  input wire logic tx_serial_out_o,
  input wire logic tx_serial_oe_n_o,
  input wire logic tx_path_powerdown_i,
  input wire logic rx_path_powerdown_i,
  input wire logic tx_sample_take_o,
  input wire logic [15:0] rx_sample_o,
  input wire logic rx_sample_valid_o
);
  logic [7:0] drv_cnt_r;
  // Cycles driven; 16 bits take about 189
  always @(posedge clk_i) drv_cnt_r <= tx_serial_oe_n_o ? 8'h00 : drv_cnt_r + 8'h01;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_idle; tx_serial_oe_n_o |-> !tx_serial_out_o; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_gap; $rose(tx_serial_oe_n_o) |=> tx_serial_oe_n_o [*8]; endproperty
  a_gap: assert property (p_gap) else $error("restart");
  property p_start;
    $fell(tx_serial_oe_n_o) |-> tx_sample_take_o && !tx_serial_out_o; endproperty
  a_start: assert property (p_start) else $error("start");
  property p_ref; tx_sample_take_o |-> $past(tx_master_clk_i, 2) && !$past(tx_master_clk_i)
    && !$past(tx_frame_sync_n_i); endproperty
  a_ref: assert property (p_ref) else $error("ref edge");
  property p_len; $rose(tx_serial_oe_n_o) && !$past(tx_path_powerdown_i)
    |-> drv_cnt_r inside {[185:195]}; endproperty
  a_len: assert property (p_len) else $error("length");
  property p_txpd; tx_path_powerdown_i |=> tx_serial_oe_n_o && !tx_sample_take_o; endproperty
  a_txpd: assert property (p_txpd) else $error("tx off");
  property p_rxpd; rx_path_powerdown_i ##1 rx_path_powerdown_i |-> !rx_sample_valid_o; endproperty
  a_rxpd: assert property (p_rxpd) else $error("rx off");
  property p_hold; !rx_sample_valid_o |-> $stable(rx_sample_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_vld; rx_sample_valid_o |=> !rx_sample_valid_o [*8]; endproperty
  a_vld: assert property (p_vld) else $error("pulse");
endmodule // lpcm_port_sva
bind lpcm_port lpcm_port_sva u_sva (.*);
`default_nettype wire

// file: testbench.sv
// Bench for lpcm_port with one shared master clock and sync.
// Assumes the checker and the far-end model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module testbench;
  logic clk_i = 1'b0, rst_n = 1'b0, tpd = 1'b0, rpd = 1'b0;
  logic tsel = 1'b0, rsel = 1'b0, byp = 1'b0, ok, mc, sn, sd, so, oe_n, tk, vl, ta, ra;
  logic [15:0] ts = 16'h0000, rw = 16'h0000, rs, w, e, e2;
  logic [1:0] tg, rg;
  logic [15:0] tq[$], rq[$];
  int num_errors = 0, n_checks = 0, i;
  always #20 clk_i = ~clk_i;
  lpcm_far_end u_far (.clk_i(clk_i), .word_i(rw), .mclk_o(mc), .sync_n_o(sn), .sdata_o(sd));
  lpcm_port u_dut (.clk_i(clk_i), .reset_n_i(rst_n), .tx_master_clk_i(mc),
    .tx_frame_sync_n_i(sn), .tx_serial_out_o(so), .tx_serial_oe_n_o(oe_n),
    .rx_master_clk_i(mc), .rx_frame_sync_n_i(sn), .rx_serial_in_i(sd),
    .tx_gain_select_i(tsel), .tx_filter_bypass_i(byp), .tx_path_powerdown_i(tpd),
    .rx_gain_select_i(rsel), .rx_path_powerdown_i(rpd), .tx_sample_i(ts),
    .tx_sample_take_o(tk), .rx_sample_o(rs), .rx_sample_valid_o(vl),
    .tx_gain_o(tg), .rx_gain_o(rg), .tx_active_o(ta), .rx_active_o(ra));
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic frame(input logic ab, input logic pd);
    @(negedge clk_i);
    ts = 16'($urandom);
    rw = 16'($urandom);
    tpd = pd;
    rpd = pd;
    if (pd) repeat (3200) @(negedge clk_i);
    if (!pd) begin
      tq.push_back(ts & 16'hFFFE);
      rq.push_back(rw);
      for (i = 0; i < 4000 && tk !== 1'b1; i++) @(negedge clk_i);
      // Abort the encoder mid-word: no transmit compare expected, receive word still checked
      if (ab) begin
        repeat (40) @(negedge clk_i);
        tpd = 1'b1;
        @(negedge clk_i);
      end
      tpd = 1'b0;
      for (i = i; i < 4000 && vl !== 1'b1; i++) @(negedge clk_i);
      if (i >= 4000) num_errors++;
    end
    tpd = 1'b0;
    rpd = 1'b0;
  endtask
  initial forever begin
    @(negedge clk_i);
    if (tk === 1'b1) begin
      w = {so, 15'h0000};
      ok = !oe_n;
      `CHK({ta, ra}, 2'b11)
      repeat (15) begin
        @(negedge mc);
        ok = ok & !oe_n;
        w = {so, w[15:1]};
      end
      e = tq.size() ? tq.pop_front() : 16'hXXXX;
      if (ok) `CHK(w, e)
    end
  end
  always @(negedge clk_i) if (vl === 1'b1) begin
    e2 = rq.size() ? rq.pop_front() : 16'hXXXX;
    `CHK(rs, e2)
    `CHK(ra, 1'b0)
  end
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(29284));
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_n = 1'b1;
    for (i = 0; i < 8; i++) begin
      @(negedge clk_i);
      {byp, tsel, rsel} = 3'(i);
      #1;
      `CHK(tg, byp ? 2'h3 : tsel ? 2'h2 : 2'h0)
      `CHK(rg, {1'b0, rsel})
    end
    frame(1'b0, 1'b0);
    frame(1'b1, 1'b0);
    frame(1'b0, 1'b1);
    frame(1'b0, 1'b0);
    repeat (9) @(negedge clk_i);
    `CHK(tq.size() + rq.size(), 0)
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
